// >>> rtl/hpm_defs.vh
// hpm_defs.vh: offsets, field positions, reset values and timing counts for the host/phy pin mux
// assumes: included by hpm_pin_mux.v only, plain verilog-2005
`ifndef HPM_DEFS_VH
`define HPM_DEFS_VH
// register offsets (byte addresses, one 32-bit word each)
`define HPM_MODULE_CONFIG_REGISTER 8'h00
`define HPM_DEBUG_PORT_CTRL 8'h04
`define HPM_DRIVE_STRENGTH 8'h08
`define HPM_HOST_PIN_PULL_ENABLE 8'h0c
`define HPM_HOST_PIN_PULL_DIRECTION 8'h10
`define HPM_STATUS 8'h14
`define HPM_HOST_WDATA 8'h18
`define HPM_HOST_RDATA 8'h1c
`define HPM_HOST_ADDR 8'h20
// module config field: phy type select bits [1:0]
`define HPM_PHY_TYPE_LSB 0
`define HPM_PHY_BG 2'h0
`define HPM_PHY_RS485 2'h1
// host mode strap codes
`define HPM_MODE_ASYNC_MEM 2'h0
`define HPM_MODE_MUXED 2'h1
// reset values
`define HPM_PULL_EN_RST 32'h0000_0000
`define HPM_PULL_DIR_RST 32'h0000_0000
`define HPM_DRIVE_RST 32'h0000_003f
`define HPM_MCR_RST 2'h0
`define HPM_DBG_RST 4'h0
// timing: strap latch window and clock out
`define HPM_CLK_HZ 40000000
`define HPM_STRAP_NS 200
`define HPM_STRAP_CYC ((`HPM_STRAP_NS * (`HPM_CLK_HZ / 1000000) + 999) / 1000)
`define HPM_BUS_CLK_MAX_HZ 8000000
`endif

// >>> rtl/hpm_pin_mux.v
// hpm_pin_mux.v: host and phy pin function multiplexer with strap latch and pin control registers
// assumes: mclk_i 40 mhz, pins sampled through two flip-flops, register port driven on mclk_i
//
// Behaviour
// - async mode six inputs are address 1..6; muxed mode expanded address 19..14.
// - expanded address 14 is the least significant of the six.
// - next three inputs are address 7..9 or address select 0..2.
// - async mode, low output enable drives the 16 data pins on read.
// - muxed mode uses six address selects, output enable pin is select 3.
// - async mode, sixteen pins are data, bit 0 least significant.
// - muxed mode, sixteen pins carry address then data, line 0 lsb; the code uses them for data only, host address 13..0 stays zero.
// - write enable strobe captures host data in async mode.
// - host mode and clock select straps sampled during internal reset.
// - while latching, strap pins undriven and pulled down.
// - latched clock select straps choose external clock output rate.
// - receive pins go to channels 1 and 2 for any phy type; phy type field sets the rs485 flag.
// - guardian tick output driven for any phy type.
// - guardian macrotick output driven for any phy type.
// - guardian arm output driven for any phy type.
// - debug control register picks each debug strobe's function.
// - software selects full or reduced drive per output pin.
// - software enables pull and chooses direction per input pin.
// - all pulls disabled after reset.
// - drive strength bits 5:0 full after reset, the others reduced.
//
// operating notes
// every pin input passes two flip-flops first
// so a pin change shows on a decoded output
// three clock edges later
// two edges for the synchroniser
// one edge for the output register
// the host must hold levels longer than that
// a pulse shorter than a clock is lost
//
// strap window
// the window opens when reset is released
// it lasts strap_cyc plus one clock edges
// the synchroniser holds zero for two edges
// so the last sample of the window is the one kept
// strap_cyc below two would keep a stale zero
// shared pins are not driven in the window
// the pulldown request stays high in the window
// external pulls set the strapped levels
// after the window the guardian pins drive
// the straps then stay frozen until reset
//
// strap codes
// host mode is txd1 then tick
// zero selects the async memory host mode
// any other code selects the muxed mode
// clock select is mtick then arm
// zero stops the external clock output
// one gives a tenth of the core clock
// two gives a quarter of the core clock
// three toggles on every core clock edge
//
// async memory mode
// six low address pins are address 1 to 6
// three middle pins are address 7 to 9
// bit 0 of the host address is always zero
// output enable low drives the data pins
// the read word register feeds the data pins
// data pins are captured while write is low
// the last word before write rises is kept
// the host may drop data as write rises
// because both cross the same synchroniser
//
// muxed mode
// six low address pins are address 19 to 14
// three middle pins are selects 0 to 2
// the output enable pin is select 3
// two high pins are selects 4 and 5
// write enable pin is read/write, high reads
// data pins drive while reading and clock high
// a write word is taken at the bus clock rise
// the bus clock is sampled, not used as a clock
// so it must stay well below the core clock
//
// receive pins
// pin 1 goes to channel 1, pin 2 to channel 2
// the routing is the same for either phy type
// the phy type only sets the rs485 flag
//
// guardian and debug pins
// tick, macrotick and arm follow their sources
// debug control bit 0 puts debug on arm
// debug control bit 1 puts debug on tick
// debug control bits 3:2 pick the source
// macrotick never carries a debug source
//
// pad control
// drive register, one bit per output pin
// a one asks for full drive
// pull enable register, one bit per pin
// pull direction register, a one pulls up
// pad controls reach the pads one edge late
//
// register port
// writes take effect on the next edge
// read data stand for one cycle only
// the read data output is zero otherwise
// unmapped addresses read zero
// writes to unmapped addresses are ignored
// the slave never stalls the master
//
// limitations
// no interrupt logic lives in this block
// no transmit pins are handled here
// the host address view is for the core only
// no byte lanes: the word is always 16 bits
// the chip select is synchronised
// but not used by this block
//
`include "hpm_defs.vh"
module hpm_pin_mux #(
    parameter STRAP_CYC = `HPM_STRAP_CYC,
    parameter DW = 16
) (
    input wire mclk_i,
    input wire rst_n_i,
    // register port
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    // host address pins
    input wire [5:0] haddr_lo_i,
    input wire [2:0] haddr_mid_i,
    input wire read_oe_n_i,
    input wire [1:0] address_select_hi_i,
    input wire chip_sel_n_i,
    input wire write_en_n_i,
    input wire host_bus_clock_in_i,
    // data pins
    input wire [DW-1:0] data_pin_i,
    output reg [DW-1:0] data_pin_o,
    output reg data_pin_oe_o,
    // shared guardian / debug / strap pins
    input wire tick_pin_i,
    output reg tick_pin_o,
    output reg tick_pin_oe_o,
    input wire mtick_pin_i,
    output reg mtick_pin_o,
    output reg mtick_pin_oe_o,
    input wire arm_pin_i,
    output reg arm_pin_o,
    output reg arm_pin_oe_o,
    input wire txd1_pin_i,
    output reg strap_pulldown_o,
    // receive pins and core-side channels
    input wire [1:0] phy_receive_data_i,
    output reg [1:0] rx_channel_o,
    output reg rx_is_rs485_o,
    // core-side guardian and debug sources
    input wire guardian_tick_src_i,
    input wire guardian_macrotick_src_i,
    input wire guardian_arm_src_i,
    input wire [3:0] debug_src_i,
    // external clock output
    output reg external_clock_output_o,
    // pad control
    output reg [31:0] drive_full_o,
    output reg [31:0] pull_enable_o,
    output reg [31:0] pull_up_o,
    // decoded host view
    output reg [1:0] host_mode_o,
    output reg [19:0] host_addr_o,
    output reg [5:0] address_select_o,
    output reg host_write_o
);
    localparam ST_LATCH = 2'h0;
    localparam ST_RUN = 2'h1;

    // two-flop synchronisers for all pin inputs
    localparam SW = 6 + 3 + 1 + 2 + 1 + 1 + 1 + DW + 4 + 2;
    wire [SW-1:0] raw = {haddr_lo_i, haddr_mid_i, read_oe_n_i, address_select_hi_i, chip_sel_n_i, write_en_n_i,
        host_bus_clock_in_i, data_pin_i, tick_pin_i, mtick_pin_i, arm_pin_i, txd1_pin_i, phy_receive_data_i};
    reg [SW-1:0] s1_r;
    reg [SW-1:0] s2_r;
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= {SW{1'b0}};
            s2_r <= {SW{1'b0}};
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end
    wire [5:0] a_lo = s2_r[SW-1 -: 6];
    wire [2:0] a_mid = s2_r[SW-7 -: 3];
    wire oe_n = s2_r[SW-10];
    wire [1:0] sel_hi = s2_r[SW-11 -: 2];
    wire we_n = s2_r[SW-14];
    wire bclk = s2_r[SW-15];
    wire [DW-1:0] dpin = s2_r[SW-16 -: DW];
    wire st_tick = s2_r[5];
    wire st_mtick = s2_r[4];
    wire st_arm = s2_r[3];
    wire st_txd1 = s2_r[2];
    wire [1:0] rxd = s2_r[1:0];

    // strap latch sequencer: pins released and pulled down during the window
    reg [1:0] state_r;
    reg [15:0] cnt_r;
    reg [1:0] mode_r;
    reg [1:0] clk_sel_r;
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_LATCH;
            cnt_r <= 16'h0000;
            mode_r <= 2'h0;
            clk_sel_r <= 2'h0;
        end else begin
            case (state_r)
                ST_LATCH: begin
                    mode_r <= {st_txd1, st_tick};
                    clk_sel_r <= {st_mtick, st_arm};
                    if (cnt_r == STRAP_CYC[15:0]) begin
                        state_r <= ST_RUN;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_RUN: begin
                    state_r <= ST_RUN; // straps frozen
                end
                default: begin
                    state_r <= ST_LATCH;
                end
            endcase
        end
    end
    wire run = (state_r == ST_RUN);

    // software registers
    reg [1:0] phy_type_r;
    reg [3:0] dbg_r;
    reg [31:0] drive_r;
    reg [31:0] pull_en_r;
    reg [31:0] pull_dir_r;
    reg [DW-1:0] rd_word_r;
    reg [DW-1:0] wr_word_r;
    reg bclk_d_r;
    wire mode_async = (mode_r == `HPM_MODE_ASYNC_MEM);
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phy_type_r <= `HPM_MCR_RST;
            dbg_r <= `HPM_DBG_RST;
            drive_r <= `HPM_DRIVE_RST;
            pull_en_r <= `HPM_PULL_EN_RST;
            pull_dir_r <= `HPM_PULL_DIR_RST;
            rd_word_r <= {DW{1'b0}};
            wr_word_r <= {DW{1'b0}};
            bclk_d_r <= 1'b0;
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            bclk_d_r <= bclk;
            // track host data while write enable is low, last word kept
            if (run && mode_async && !we_n) begin
                wr_word_r <= dpin;
            end
            if (run && !mode_async && !bclk_d_r && bclk && !we_n) begin
                wr_word_r <= dpin;
            end
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `HPM_MODULE_CONFIG_REGISTER: phy_type_r <= reg_wdata_i[`HPM_PHY_TYPE_LSB +: 2];
                    `HPM_DEBUG_PORT_CTRL: dbg_r <= reg_wdata_i[3:0];
                    `HPM_DRIVE_STRENGTH: drive_r <= reg_wdata_i;
                    `HPM_HOST_PIN_PULL_ENABLE: pull_en_r <= reg_wdata_i;
                    `HPM_HOST_PIN_PULL_DIRECTION: pull_dir_r <= reg_wdata_i;
                    `HPM_HOST_RDATA: rd_word_r <= reg_wdata_i[DW-1:0];
                    default: ;
                endcase
            end
            reg_rdata_o <= 32'h0000_0000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `HPM_MODULE_CONFIG_REGISTER: reg_rdata_o <= {30'h0, phy_type_r};
                    `HPM_DEBUG_PORT_CTRL: reg_rdata_o <= {28'h0, dbg_r};
                    `HPM_DRIVE_STRENGTH: reg_rdata_o <= drive_r;
                    `HPM_HOST_PIN_PULL_ENABLE: reg_rdata_o <= pull_en_r;
                    `HPM_HOST_PIN_PULL_DIRECTION: reg_rdata_o <= pull_dir_r;
                    `HPM_STATUS: reg_rdata_o <= {27'h0, run, clk_sel_r, mode_r};
                    `HPM_HOST_WDATA: reg_rdata_o <= {{(32-DW){1'b0}}, wr_word_r};
                    `HPM_HOST_RDATA: reg_rdata_o <= {{(32-DW){1'b0}}, rd_word_r};
                    `HPM_HOST_ADDR: reg_rdata_o <= {12'h0, host_addr_o};
                    default: reg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // external clock divider: 4, 10 or 20 mhz, or off
    reg [2:0] div_r;
    reg ck_r;
    wire [2:0] half = (clk_sel_r == 2'h1) ? 3'h4 : 3'h1;
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_r <= 3'h0;
            ck_r <= 1'b0;
        end else if (div_r >= half) begin
            div_r <= 3'h0;
            ck_r <= ~ck_r;
        end else begin
            div_r <= div_r + 3'h1;
        end
    end

    // pin function routing
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_pin_o <= {DW{1'b0}};
            data_pin_oe_o <= 1'b0;
            tick_pin_o <= 1'b0;
            tick_pin_oe_o <= 1'b0;
            mtick_pin_o <= 1'b0;
            mtick_pin_oe_o <= 1'b0;
            arm_pin_o <= 1'b0;
            arm_pin_oe_o <= 1'b0;
            strap_pulldown_o <= 1'b1;
            rx_channel_o <= 2'h0;
            rx_is_rs485_o <= 1'b0;
            external_clock_output_o <= 1'b0;
            drive_full_o <= `HPM_DRIVE_RST;
            pull_enable_o <= `HPM_PULL_EN_RST;
            pull_up_o <= `HPM_PULL_DIR_RST;
            host_mode_o <= 2'h0;
            host_addr_o <= 20'h00000;
            address_select_o <= 6'h00;
            host_write_o <= 1'b0;
        end else begin
            strap_pulldown_o <= ~run;
            tick_pin_oe_o <= run;
            mtick_pin_oe_o <= run;
            arm_pin_oe_o <= run;
            tick_pin_o <= dbg_r[1] ? debug_src_i[dbg_r[3:2]] : guardian_tick_src_i;
            mtick_pin_o <= guardian_macrotick_src_i;
            arm_pin_o <= dbg_r[0] ? debug_src_i[dbg_r[3:2]] : guardian_arm_src_i;
            rx_channel_o <= rxd; // pin 1 -> channel 1, pin 2 -> channel 2
            rx_is_rs485_o <= (phy_type_r == `HPM_PHY_RS485);
            external_clock_output_o <= (clk_sel_r == 2'h0) ? 1'b0 : (clk_sel_r == 2'h3) ? ~external_clock_output_o : ck_r;
            drive_full_o <= drive_r;
            pull_enable_o <= pull_en_r;
            pull_up_o <= pull_dir_r;
            host_mode_o <= mode_r;
            if (mode_async) begin
                host_addr_o <= {10'h000, a_mid, a_lo, 1'b0};
                address_select_o <= 6'h00;
                data_pin_oe_o <= run && !oe_n;
                data_pin_o <= rd_word_r;
                host_write_o <= !we_n;
            end else begin
                host_addr_o <= {a_lo, 14'h0000};
                address_select_o <= {sel_hi, oe_n, a_mid};
                data_pin_oe_o <= run && we_n && bclk;
                data_pin_o <= rd_word_r;
                host_write_o <= !we_n;
            end
        end
    end
endmodule // hpm_pin_mux

// >>> verification/hpm_host_model.sv
// hpm_host_model.sv: host processor on the mux's host pins, either mode
// assumes: request fields change just after mclk edges
module hpm_host_model (
    input logic muxed_i,
    input logic [19:0] addr_i,
    input logic [5:0] sel_i,
    input logic rd_i,
    input logic wr_i,
    input logic [15:0] wdata_i,
    output logic [5:0] haddr_lo_o,
    output logic [2:0] haddr_mid_o,
    output logic read_oe_n_o,
    output logic [1:0] sel_hi_o,
    output logic chip_sel_n_o,
    output logic write_en_n_o,
    output logic bus_clk_o,
    output logic [15:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] last_r = 16'h0;
    // address and select pins, lsb first
    assign haddr_lo_o = muxed_i ? addr_i[19:14] : addr_i[6:1];
    assign haddr_mid_o = muxed_i ? sel_i[2:0] : addr_i[9:7];
    assign read_oe_n_o = muxed_i ? sel_i[3] : !rd_i;
    assign sel_hi_o = muxed_i ? sel_i[5:4] : 2'h0;
    assign chip_sel_n_o = muxed_i ? 1'b0 : !(rd_i || wr_i);
    assign write_en_n_o = !wr_i;
    // data only while writing, else inverse of last
    assign data_o = wr_i ? wdata_i : ~last_r;
    always @(wr_i or wdata_i) if (wr_i) last_r = wdata_i;
    // 5 mhz bus clock, still outside muxed mode
    initial bus_clk_o = 1'b0;
    always #100 bus_clk_o = muxed_i ? !bus_clk_o : 1'b0;
endmodule // hpm_host_model

// >>> verification/hpm_pin_mux_props.sv
// hpm_pin_mux_props.sv: port timing checks for the pin mux
// assumes: bound into hpm_pin_mux, single mclk_i domain
module hpm_pin_mux_props #(
    parameter STRAP_CYC = 2,
    parameter DW = 16
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire [5:0] haddr_lo_i,
    input wire [2:0] haddr_mid_i,
    input wire read_oe_n_i,
    input wire [1:0] address_select_hi_i,
    input wire [1:0] phy_receive_data_i,
    input wire [1:0] rx_channel_o,
    input wire tick_pin_oe_o,
    input wire mtick_pin_oe_o,
    input wire arm_pin_oe_o,
    input wire strap_pulldown_o,
    input wire [31:0] drive_full_o,
    input wire [31:0] pull_enable_o,
    input wire [1:0] host_mode_o,
    input wire [19:0] host_addr_o,
    input wire [5:0] address_select_o
);
    logic [3:0] up_cnt_r;
    // cycles since reset release, saturating
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) up_cnt_r <= 4'h0;
        else if (up_cnt_r != 4'hf) up_cnt_r <= up_cnt_r + 4'h1;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    AST_DRIVE_WR: assert property (reg_wr_i && reg_addr_i == 8'h08 |-> ##2 drive_full_o == $past(reg_wdata_i, 2))
        else $error("drive write lost");
    AST_PULL_WR: assert property (reg_wr_i && reg_addr_i == 8'h0c |-> ##2 pull_enable_o == $past(reg_wdata_i, 2))
        else $error("pull write lost");
    AST_STRAP_HIZ: assert property (strap_pulldown_o |-> !tick_pin_oe_o && !mtick_pin_oe_o && !arm_pin_oe_o)
        else $error("strap pin driven");
    AST_MODE_HOLD: assert property (up_cnt_r == 4'hf |-> $stable(host_mode_o))
        else $error("host mode moved");
    AST_GUARD_OE: assert property (up_cnt_r == 4'hf |-> tick_pin_oe_o && mtick_pin_oe_o && arm_pin_oe_o)
        else $error("guardian pin idle");
    AST_RX_MAP: assert property (up_cnt_r == 4'hf |-> rx_channel_o == $past(phy_receive_data_i, 3))
        else $error("rx channel map");
    AST_ASYNC_ADDR: assert property (up_cnt_r == 4'hf && host_mode_o == 2'h0
        |-> host_addr_o[9:1] == {$past(haddr_mid_i, 3), $past(haddr_lo_i, 3)})
        else $error("async address map");
    AST_MUX_ADDR: assert property (up_cnt_r == 4'hf && host_mode_o != 2'h0
        |-> host_addr_o[19:14] == $past(haddr_lo_i, 3) && address_select_o
        == {$past(address_select_hi_i, 3), $past(read_oe_n_i, 3), $past(haddr_mid_i, 3)})
        else $error("muxed address map");
endmodule // hpm_pin_mux_props
bind hpm_pin_mux hpm_pin_mux_props #(.STRAP_CYC(STRAP_CYC), .DW(DW)) u_hpm_pin_mux_props (.*);

// >>> verification/tb_hpm_pin_mux.sv
// tb_hpm_pin_mux.sv: self-checking bench for the host/phy pin mux
// assumes: 40 mhz mclk_i, strap window shortened to 3 cycles (STRAP_CYC 2)
module tb_hpm_pin_mux;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, h_mux = 0, h_rd = 0, h_wr = 0, g_r = 0;
    logic [7:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, drive_full_o, pull_enable_o, pull_up_o, d;
    logic [19:0] h_a = 0, host_addr_o;
    logic [15:0] h_wd = 0, hdata, data_pin_o;
    logic [5:0] h_acs = 0, haddr_lo_i, address_select_o;
    logic [3:0] strap_r = 0, debug_src_i = 0;
    logic [2:0] haddr_mid_i;
    logic [1:0] address_select_hi_i, phy_receive_data_i = 0, rx_channel_o, host_mode_o;
    logic read_oe_n_i, chip_sel_n_i, write_en_n_i, host_bus_clock_in_i, data_pin_oe_o, tick_pin_o, tick_pin_oe_o;
    logic mtick_pin_o, mtick_pin_oe_o, arm_pin_o, arm_pin_oe_o, strap_pulldown_o, rx_is_rs485_o;
    logic external_clock_output_o, host_write_o;
    int err_count = 0, compares = 0, cyc_cnt = 0, n;
    logic [7:0] ra [6] = '{8'h08, 8'h0c, 8'h10, 8'h00, 8'h04, 8'hfc};
    logic [31:0] rw [6] = '{32'h15, 32'h2a5, 32'h1c3, 32'h1, 32'hd, 32'hffff};
    logic [31:0] re [6] = '{32'h15, 32'h2a5, 32'h1c3, 32'h1, 32'hd, 32'h0};
    always #12.5 mclk_i = !mclk_i;
    hpm_host_model u_hpm_host_model (.muxed_i(h_mux), .addr_i(h_a), .sel_i(h_acs), .rd_i(h_rd), .wr_i(h_wr),
        .wdata_i(h_wd), .haddr_lo_o(haddr_lo_i), .haddr_mid_o(haddr_mid_i), .read_oe_n_o(read_oe_n_i),
        .sel_hi_o(address_select_hi_i), .chip_sel_n_o(chip_sel_n_i), .write_en_n_o(write_en_n_i),
        .bus_clk_o(host_bus_clock_in_i), .data_o(hdata));
    hpm_pin_mux #(.STRAP_CYC(2)) u_hpm_pin_mux (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .haddr_lo_i(haddr_lo_i), .haddr_mid_i(haddr_mid_i), .read_oe_n_i(read_oe_n_i),
        .address_select_hi_i(address_select_hi_i), .chip_sel_n_i(chip_sel_n_i), .write_en_n_i(write_en_n_i),
        .host_bus_clock_in_i(host_bus_clock_in_i), .data_pin_i(data_pin_oe_o ? data_pin_o : hdata),
        .data_pin_o(data_pin_o), .data_pin_oe_o(data_pin_oe_o), .tick_pin_i(tick_pin_oe_o ? tick_pin_o : strap_r[2]),
        .tick_pin_o(tick_pin_o), .tick_pin_oe_o(tick_pin_oe_o), .mtick_pin_i(mtick_pin_oe_o ? mtick_pin_o : strap_r[1]),
        .mtick_pin_o(mtick_pin_o), .mtick_pin_oe_o(mtick_pin_oe_o), .arm_pin_i(arm_pin_oe_o ? arm_pin_o : strap_r[0]),
        .arm_pin_o(arm_pin_o), .arm_pin_oe_o(arm_pin_oe_o), .txd1_pin_i(strap_r[3]), .strap_pulldown_o(strap_pulldown_o),
        .phy_receive_data_i(phy_receive_data_i), .rx_channel_o(rx_channel_o), .rx_is_rs485_o(rx_is_rs485_o),
        .guardian_tick_src_i(g_r), .guardian_macrotick_src_i(g_r), .guardian_arm_src_i(g_r), .debug_src_i(debug_src_i),
        .external_clock_output_o(external_clock_output_o), .drive_full_o(drive_full_o), .pull_enable_o(pull_enable_o),
        .pull_up_o(pull_up_o), .host_mode_o(host_mode_o), .host_addr_o(host_addr_o),
        .address_select_o(address_select_o), .host_write_o(host_write_o));
    task automatic complete_run();
        if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge mclk_i);
        reg_wr_i <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 0;
        #1 d = reg_rdata_o;
    endtask
    // reset with given straps {txd1,tick,mtick,arm}, then check reset state
    task automatic do_reset(input logic [3:0] s);
        logic pv;
        @(posedge mclk_i);
        rst_n_i <= 0;
        strap_r <= s;
        cyc(12);
        chk("pulldown", strap_pulldown_o, 1);
        rst_n_i <= 1;
        cyc(20);
        chk("drive rst", drive_full_o, 32'h3f);
        chk("pull rst", pull_enable_o, 0);
        chk("pullup rst", pull_up_o, 0);
        chk("mode", host_mode_o, s[3:2]);
        rd(8'h14);
        chk("status", d & 32'h1f, {1'b1, s[1:0], s[3:2]});
        n = 0;
        pv = external_clock_output_o;
        repeat (100) begin
            cyc(1);
            if (external_clock_output_o && !pv) n++;
            pv = external_clock_output_o;
        end
    endtask
    // hang guard
    always @(posedge mclk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        do_reset(4'h0);
        chk("clock off", n, 0);
        for (int i = 0; i < 6; i++) begin
            wr(ra[i], rw[i]);
            rd(ra[i]);
            chk("reg row", d, re[i]);
        end
        h_a <= 20'h003a6;
        wr(8'h1c, 32'ha5c3);
        h_rd <= 1;
        cyc(5);
        chk("async addr", host_addr_o[9:1], h_a[9:1]);
        chk("read oe", data_pin_oe_o, 1);
        chk("read data", data_pin_o, 16'ha5c3);
        h_rd <= 0;
        h_wd <= 16'h3c5a;
        h_wr <= 1;
        cyc(5);
        chk("oe off", data_pin_oe_o, 0);
        h_wr <= 0;
        cyc(5);
        rd(8'h18);
        chk("write data", d, 32'h3c5a);
        wr(8'h04, 0);
        for (int p = 0; p < 2; p++) begin
            wr(8'h00, p);
            phy_receive_data_i <= 2'h2;
            g_r <= 1;
            cyc(5);
            chk("rx ch", rx_channel_o, 2'h2);
            chk("rs485", rx_is_rs485_o, p);
            chk("guard on", {tick_pin_o, mtick_pin_o, arm_pin_o}, 3'h7);
            g_r <= 0;
            phy_receive_data_i <= 2'h1;
            cyc(5);
            chk("guard off", {tick_pin_o, mtick_pin_o, arm_pin_o, rx_channel_o}, 5'h1);
        end
        for (int i = 0; i < 2; i++) begin
            wr(8'h04, 32'h8 | (1 << i));
            debug_src_i <= 4'h4;
            cyc(5);
            chk("debug on", i ? tick_pin_o : arm_pin_o, 1);
            debug_src_i <= 4'hb;
            cyc(5);
            chk("debug off", i ? tick_pin_o : arm_pin_o, 0);
        end
        do_reset(4'h5);
        chk("clock 4mhz", n >= 9 && n <= 11, 1);
        h_mux <= 1;
        h_a <= 20'hb4000;
        h_acs <= 6'h2b;
        h_wr <= 1;
        cyc(5);
        chk("expanded_address_in", host_addr_o[19:14], 6'h2d);
        chk("acs", address_select_o, 6'h2b);
        chk("rw write", host_write_o, 1);
        h_wr <= 0;
        cyc(5);
        chk("rw read", host_write_o, 0);
        complete_run();
    end
endmodule // tb_hpm_pin_mux
